/* File: logic/lapt_pkg.sv */
package lapt_pkg;

	// Register byte offsets
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_DWELL  = 8'h04;
	localparam logic [7:0] REG_LENGTH = 8'h08;
	localparam logic [7:0] REG_XPOS   = 8'h0C;
	localparam logic [7:0] REG_YPOS   = 8'h10;
	localparam logic [7:0] REG_IMG_W  = 8'h14;
	localparam logic [7:0] REG_IMG_H  = 8'h18;
	localparam logic [7:0] REG_STATUS = 8'h1C;
	localparam logic [7:0] REG_TCODE  = 8'h20;

	// Control register fields
	localparam int CTL_AUTO  = 0;
	localparam int CTL_LOOP  = 1;
	localparam int CTL_DWELL = 2;
	localparam int CTL_PMODE = 4;
	localparam int CTL_TCSZ  = 6;
	localparam int CTL_FMT   = 8;

	// Status register fields
	localparam int STS_STATE = 16;
	localparam int STS_LOCK  = 20;
	localparam int STS_DROP  = 21;

	localparam int FRAME_W = 14;
	localparam int WIDTH_W = 17;
	localparam logic [FRAME_W-1:0] MAX_FRAMES  = 14'h2710;
	localparam logic [WIDTH_W-1:0] MAX_W_INTL  = 17'h08000;
	localparam logic [WIDTH_W-1:0] MAX_W_PROG  = 17'h10000;
	localparam logic [FRAME_W-1:0] RST_LENGTH  = 14'h0001;
	localparam logic [15:0]        RST_DWELL   = 16'h0000;

	typedef enum logic [2:0] {
		FMT_480I59  = 3'h0,
		FMT_576I50  = 3'h1,
		FMT_1080I59 = 3'h2,
		FMT_1080I50 = 3'h3,
		FMT_SF23    = 3'h4,
		FMT_SF24    = 3'h5,
		FMT_720P50  = 3'h6,
		FMT_720P59  = 3'h7
	} lapt_fmt_e;

	// Highest displayed frame count per format
	localparam logic [6:0] FF_MAX_59I = 7'h1D;
	localparam logic [6:0] FF_MAX_50I = 7'h18;
	localparam logic [6:0] FF_MAX_SF  = 7'h17;
	localparam logic [6:0] FF_MAX_50P = 7'h31;
	localparam logic [6:0] FF_MAX_59P = 7'h3B;

	// Active raster sizes
	localparam logic [WIDTH_W-1:0] SCR_W_SD  = 17'h002D0;
	localparam logic [WIDTH_W-1:0] SCR_W_HD  = 17'h00780;
	localparam logic [WIDTH_W-1:0] SCR_W_720 = 17'h00500;
	localparam logic [15:0]        SCR_H_480 = 16'h01E6;
	localparam logic [15:0]        SCR_H_576 = 16'h0240;
	localparam logic [15:0]        SCR_H_HD  = 16'h0438;
	localparam logic [15:0]        SCR_H_720 = 16'h02D0;

	// Gray along IDLE, PLAY, DWELL, HOLD
	typedef enum logic [1:0] {
		SEQ_IDLE  = 2'h0,
		SEQ_PLAY  = 2'h1,
		SEQ_DWELL = 2'h3,
		SEQ_HOLD  = 2'h2
	} lapt_seq_e;

	typedef struct packed {
		logic        auto_start;
		logic        loop;
		logic        dwell_en;
		logic [15:0] dwell;
		logic [15:0] xpos;
		logic [15:0] ypos;
	} lapt_clip_s;

	typedef struct packed {
		logic       drop;
		logic [6:0] hh;
		logic [6:0] mm;
		logic [6:0] ss;
		logic [6:0] ff;
	} lapt_tc_s;

	typedef struct packed {
		logic            dashes;
		logic            drop;
		logic [1:0]      size;
		logic [7:0][3:0] digits;
	} lapt_ovl_s;

endpackage

/* File: logic/lapt_core.sv */
// Function
// - Auto start on: every take to air restarts at the first frame.
// - Auto start off: a take to air leaves playback untouched.
// - Looping on: after the last frame wrap to the first, forever.
// - Looping off: play once, then keep showing the last frame.
// - Dwell on: hold the last frame for the set frame count first.
// - Auto start plus looping: each new take restarts, then keeps looping.
// - Field play mode acts only on interlaced formats.
// - Position clamped on screen; full-screen images ignore position.
// - Crop width to 32768 interlaced, 65536 progressive.
// - Animations up to 10000 frames long.
// - Clip without stored settings keeps the current play settings.
// - No timecode input: overlay shows dashes.
// - Overlay shows hours, minutes, seconds, frames and drop-frame flag.
// - Interlaced 59.94 formats count frames 00 to 29.
// - Interlaced 50 formats count frames 00 to 24.
// - Segmented 23.98 and 24 formats count frames 00 to 23.
// - 720p 50 counts frames 00 to 49.
// - 720p 59.94 counts frames 00 to 59.
// - Progressive: advance displayed frame count on every output frame.
// - Overlay character size: large, medium or small.
//
// Our own choices: the register addresses and the APB register port.
`timescale 1ns/10ps
module lapt_core (
	input  wire logic               I_CLOCK,
	input  wire logic               I_RST_N,
	input  wire logic               I_PSEL,
	input  wire logic               I_PENABLE,
	input  wire logic               I_PWRITE,
	input  wire logic [7:0]         I_PADDR,
	input  wire logic [31:0]        I_PWDATA,
	output logic [31:0]             O_PRDATA,
	output logic                    O_PREADY,
	output logic                    O_PSLVERR,
	input  wire logic               I_FRAME_SYNC,
	input  wire logic               I_TAKE,
	input  wire logic               I_CLIP_LOAD,
	input  wire logic               I_CLIP_HAS_CFG,
	input  wire lapt_pkg::lapt_clip_s I_CLIP_CFG,
	input  wire logic [13:0]        I_CLIP_LEN,
	input  wire logic [16:0]        I_CLIP_W,
	input  wire logic [15:0]        I_CLIP_H,
	input  wire logic               I_LTC_LOCK,
	input  wire logic               I_LTC_STB,
	input  wire lapt_pkg::lapt_tc_s I_LTC_TC,
	output logic [13:0]             O_FRAME_IDX,
	output logic                    O_PLAYING,
	output logic [15:0]             O_XPOS,
	output logic [15:0]             O_YPOS,
	output logic [16:0]             O_CROP_W,
	output logic [15:0]             O_CROP_H,
	output logic [1:0]              O_PLAY_MODE,
	output lapt_pkg::lapt_ovl_s     O_OVERLAY
);

	function automatic logic is_intl(input logic [2:0] f);
		return f <= 3'(lapt_pkg::FMT_1080I50);
	endfunction

	function automatic logic is_prog(input logic [2:0] f);
		return f >= 3'(lapt_pkg::FMT_720P50);
	endfunction

	function automatic logic [6:0] ff_max(input logic [2:0] f);
		case (f)
			3'(lapt_pkg::FMT_480I59), 3'(lapt_pkg::FMT_1080I59): return lapt_pkg::FF_MAX_59I;
			3'(lapt_pkg::FMT_576I50), 3'(lapt_pkg::FMT_1080I50): return lapt_pkg::FF_MAX_50I;
			3'(lapt_pkg::FMT_720P50): return lapt_pkg::FF_MAX_50P;
			3'(lapt_pkg::FMT_720P59): return lapt_pkg::FF_MAX_59P;
			default: return lapt_pkg::FF_MAX_SF;
		endcase
	endfunction

	function automatic logic [7:0] to_bcd(input logic [6:0] v);
		logic [6:0] t;
		logic [6:0] u;
		t = v / 7'h0A;
		u = v % 7'h0A;
		return {t[3:0], u[3:0]};
	endfunction

	// Register state
	logic [31:0]        ctrl_q;
	logic [15:0]        dwell_q;
	logic [13:0]        len_q;
	logic [15:0]        xpos_q;
	logic [15:0]        ypos_q;
	logic [16:0]        img_w_q;
	logic [15:0]        img_h_q;

	logic               wr_en;
	logic               rd_hit;
	logic [31:0]        rd_data;
	logic [2:0]         fmt;
	logic [13:0]        wr_len;

	assign fmt = ctrl_q[lapt_pkg::CTL_FMT +: 3];
	assign wr_en = I_PSEL & I_PENABLE & O_PREADY & I_PWRITE;

	// Lengths beyond the supported maximum are held at the maximum
	always_comb begin
		wr_len = I_PWDATA[13:0];
		if (I_PWDATA[31:0] > 32'(lapt_pkg::MAX_FRAMES)) begin
			wr_len = lapt_pkg::MAX_FRAMES;
		end
	end

	// No wait state: pready rises in the first access cycle
	always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			O_PREADY  <= 1'b0;
			O_PSLVERR <= 1'b0;
			O_PRDATA  <= 32'h0000_0000;
		end else begin
			O_PREADY  <= I_PSEL & ~I_PENABLE & ~O_PREADY;
			O_PSLVERR <= I_PSEL & ~I_PENABLE & ~O_PREADY & ~rd_hit;
			if (I_PSEL & ~I_PENABLE & ~O_PREADY & ~I_PWRITE) begin
				O_PRDATA <= rd_data;
			end
		end
	end

	// Settings: clip load wins over a bus write in the same cycle
	always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			ctrl_q  <= 32'h0000_0000;
			dwell_q <= lapt_pkg::RST_DWELL;
			xpos_q  <= 16'h0000;
			ypos_q  <= 16'h0000;
		end else if (I_CLIP_LOAD) begin
			if (I_CLIP_HAS_CFG) begin
				ctrl_q[lapt_pkg::CTL_AUTO]  <= I_CLIP_CFG.auto_start;
				ctrl_q[lapt_pkg::CTL_LOOP]  <= I_CLIP_CFG.loop;
				ctrl_q[lapt_pkg::CTL_DWELL] <= I_CLIP_CFG.dwell_en;
				dwell_q <= I_CLIP_CFG.dwell;
				xpos_q  <= I_CLIP_CFG.xpos;
				ypos_q  <= I_CLIP_CFG.ypos;
			end
		end else if (wr_en) begin
			case (I_PADDR)
				lapt_pkg::REG_CTRL:  ctrl_q  <= I_PWDATA & 32'h0000_07F7;
				lapt_pkg::REG_DWELL: dwell_q <= I_PWDATA[15:0];
				lapt_pkg::REG_XPOS:  xpos_q  <= I_PWDATA[15:0];
				lapt_pkg::REG_YPOS:  ypos_q  <= I_PWDATA[15:0];
				default: ;
			endcase
		end
	end

	// Clip geometry and length
	always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			len_q   <= lapt_pkg::RST_LENGTH;
			img_w_q <= 17'h00000;
			img_h_q <= 16'h0000;
		end else if (I_CLIP_LOAD) begin
			len_q   <= (I_CLIP_LEN > lapt_pkg::MAX_FRAMES) ? lapt_pkg::MAX_FRAMES
				: I_CLIP_LEN;
			img_w_q <= I_CLIP_W;
			img_h_q <= I_CLIP_H;
		end else if (wr_en) begin
			case (I_PADDR)
				lapt_pkg::REG_LENGTH: len_q   <= wr_len;
				lapt_pkg::REG_IMG_W:  img_w_q <= I_PWDATA[16:0];
				lapt_pkg::REG_IMG_H:  img_h_q <= I_PWDATA[15:0];
				default: ;
			endcase
		end
	end

	// Frame sync from the video timing: three stages, edge only when stable
	logic       fs_s1_q;
	logic       fs_s2_q;
	logic       fs_s3_q;
	logic       fs_lvl_q;
	logic       frame_stb;
	logic       lk_s1_q;
	logic       lk_s2_q;
	logic       lk_s3_q;
	logic       lock_q;

	always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			fs_s1_q  <= 1'b0;
			fs_s2_q  <= 1'b0;
			fs_s3_q  <= 1'b0;
			fs_lvl_q <= 1'b0;
		end else begin
			fs_s1_q <= I_FRAME_SYNC;
			fs_s2_q <= fs_s1_q;
			fs_s3_q <= fs_s2_q;
			if (fs_s2_q == fs_s3_q) begin
				fs_lvl_q <= fs_s3_q;
			end
		end
	end

	// Single per-frame strobe for every frame-rate step
	assign frame_stb = fs_s2_q & fs_s3_q & ~fs_lvl_q;

	always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			lk_s1_q <= 1'b0;
			lk_s2_q <= 1'b0;
			lk_s3_q <= 1'b0;
			lock_q  <= 1'b0;
		end else begin
			lk_s1_q <= I_LTC_LOCK;
			lk_s2_q <= lk_s1_q;
			lk_s3_q <= lk_s2_q;
			if (lk_s2_q == lk_s3_q) begin
				lock_q <= lk_s3_q;
			end
		end
	end

	// Sequencer
	lapt_pkg::lapt_seq_e seq_q;
	logic [13:0]         frame_q;
	logic [15:0]         dwell_cnt_q;
	logic [13:0]         last;
	logic                auto_on;
	logic                loop_on;
	logic                dwell_on;

	assign last     = (len_q == 14'h0000) ? 14'h0000 : 14'(len_q - 14'h0001);
	assign auto_on  = ctrl_q[lapt_pkg::CTL_AUTO];
	assign loop_on  = ctrl_q[lapt_pkg::CTL_LOOP];
	assign dwell_on = ctrl_q[lapt_pkg::CTL_DWELL] & (dwell_q != 16'h0000);

	// A new clip starts free-running from its first frame
	always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			seq_q       <= lapt_pkg::SEQ_IDLE;
			frame_q     <= 14'h0000;
			dwell_cnt_q <= 16'h0000;
		end else if (I_CLIP_LOAD) begin
			seq_q       <= lapt_pkg::SEQ_PLAY;
			frame_q     <= 14'h0000;
			dwell_cnt_q <= 16'h0000;
		end else if (I_TAKE && auto_on) begin
			seq_q       <= lapt_pkg::SEQ_PLAY;
			frame_q     <= 14'h0000;
			dwell_cnt_q <= 16'h0000;
		end else if (frame_stb) begin
			case (seq_q)
				lapt_pkg::SEQ_PLAY: begin
					if (frame_q < last) begin
						frame_q <= 14'(frame_q + 14'h0001);
					end else if (dwell_on) begin
						seq_q       <= lapt_pkg::SEQ_DWELL;
						dwell_cnt_q <= dwell_q;
					end else if (loop_on) begin
						frame_q <= 14'h0000;
					end else begin
						seq_q <= lapt_pkg::SEQ_HOLD;
					end
				end
				lapt_pkg::SEQ_DWELL: begin
					// Dwell counts whole frames spent on the last frame
					if (dwell_cnt_q > 16'h0001) begin
						dwell_cnt_q <= 16'(dwell_cnt_q - 16'h0001);
					end else if (loop_on) begin
						seq_q       <= lapt_pkg::SEQ_PLAY;
						frame_q     <= 14'h0000;
						dwell_cnt_q <= 16'h0000;
					end else begin
						seq_q       <= lapt_pkg::SEQ_HOLD;
						dwell_cnt_q <= 16'h0000;
					end
				end
				lapt_pkg::SEQ_HOLD: begin
					// Looping switched on later restarts from the top
					if (loop_on) begin
						seq_q   <= lapt_pkg::SEQ_PLAY;
						frame_q <= 14'h0000;
					end
				end
				default: ;
			endcase
		end
	end

	// Placement and crop
	logic [16:0] scr_w;
	logic [15:0] scr_h;
	logic [16:0] vis_w;
	logic [15:0] vis_h;
	logic [16:0] x_lim;
	logic [15:0] y_lim;
	logic        full;
	logic [16:0] max_w;

	always_comb begin
		case (fmt)
			3'(lapt_pkg::FMT_480I59): begin
				scr_w = lapt_pkg::SCR_W_SD;
				scr_h = lapt_pkg::SCR_H_480;
			end
			3'(lapt_pkg::FMT_576I50): begin
				scr_w = lapt_pkg::SCR_W_SD;
				scr_h = lapt_pkg::SCR_H_576;
			end
			3'(lapt_pkg::FMT_720P50), 3'(lapt_pkg::FMT_720P59): begin
				scr_w = lapt_pkg::SCR_W_720;
				scr_h = lapt_pkg::SCR_H_720;
			end
			default: begin
				scr_w = lapt_pkg::SCR_W_HD;
				scr_h = lapt_pkg::SCR_H_HD;
			end
		endcase
	end

	assign vis_w = (img_w_q > scr_w) ? scr_w : img_w_q;
	assign vis_h = (img_h_q > scr_h) ? scr_h : img_h_q;
	assign x_lim = 17'(scr_w - vis_w);
	assign y_lim = 16'(scr_h - vis_h);
	assign full  = (img_w_q >= scr_w) && (img_h_q >= scr_h);
	assign max_w = is_intl(fmt) ? lapt_pkg::MAX_W_INTL : lapt_pkg::MAX_W_PROG;

	always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			O_XPOS      <= 16'h0000;
			O_YPOS      <= 16'h0000;
			O_CROP_W    <= 17'h00000;
			O_CROP_H    <= 16'h0000;
			O_PLAY_MODE <= 2'h0;
			O_FRAME_IDX <= 14'h0000;
			O_PLAYING   <= 1'b0;
		end else begin
			if (full) begin
				O_XPOS <= 16'h0000;
				O_YPOS <= 16'h0000;
			end else begin
				O_XPOS <= ({1'b0, xpos_q} > x_lim) ? x_lim[15:0] : xpos_q;
				O_YPOS <= (ypos_q > y_lim) ? y_lim : ypos_q;
			end
			O_CROP_W    <= (img_w_q > max_w) ? max_w : img_w_q;
			O_CROP_H    <= img_h_q;
			O_PLAY_MODE <= is_intl(fmt) ? ctrl_q[lapt_pkg::CTL_PMODE +: 2] : 2'h0;
			O_FRAME_IDX <= frame_q;
			O_PLAYING   <= (seq_q == lapt_pkg::SEQ_PLAY);
		end
	end

	// Timecode: LTC words load it, progressive frames fill the odd counts
	lapt_pkg::lapt_tc_s tc_q;
	logic [6:0]         fmax;

	assign fmax = ff_max(fmt);

	always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			tc_q <= '0;
		end else if (I_LTC_STB) begin
			tc_q <= I_LTC_TC;
			if (is_prog(fmt)) begin
				tc_q.ff <= {I_LTC_TC.ff[5:0], 1'b0};
			end else if (I_LTC_TC.ff > fmax) begin
				tc_q.ff <= fmax;
			end
		end else if (frame_stb && is_prog(fmt) && (tc_q.ff < fmax)) begin
			tc_q.ff <= 7'(tc_q.ff + 7'h01);
		end
	end

	always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			O_OVERLAY <= '0;
		end else begin
			O_OVERLAY.dashes <= ~lock_q;
			O_OVERLAY.drop   <= tc_q.drop;
			O_OVERLAY.size   <= ctrl_q[lapt_pkg::CTL_TCSZ +: 2];
			O_OVERLAY.digits <= {to_bcd(tc_q.hh), to_bcd(tc_q.mm),
				to_bcd(tc_q.ss), to_bcd(tc_q.ff)};
		end
	end

	// Read decode
	always_comb begin
		rd_hit  = 1'b1;
		rd_data = 32'h0000_0000;
		case (I_PADDR)
			lapt_pkg::REG_CTRL:   rd_data = ctrl_q;
			lapt_pkg::REG_DWELL:  rd_data = {16'h0000, dwell_q};
			lapt_pkg::REG_LENGTH: rd_data = {18'h00000, len_q};
			lapt_pkg::REG_XPOS:   rd_data = {16'h0000, xpos_q};
			lapt_pkg::REG_YPOS:   rd_data = {16'h0000, ypos_q};
			lapt_pkg::REG_IMG_W:  rd_data = {15'h0000, img_w_q};
			lapt_pkg::REG_IMG_H:  rd_data = {16'h0000, img_h_q};
			lapt_pkg::REG_STATUS: begin
				rd_data[13:0] = frame_q;
				rd_data[lapt_pkg::STS_STATE +: 2] = seq_q;
				rd_data[lapt_pkg::STS_LOCK] = lock_q;
				rd_data[lapt_pkg::STS_DROP] = tc_q.drop;
			end
			lapt_pkg::REG_TCODE:  rd_data = {to_bcd(tc_q.hh), to_bcd(tc_q.mm),
				to_bcd(tc_q.ss), to_bcd(tc_q.ff)};
			default:              rd_hit = 1'b0;
		endcase
	end

endmodule

/* File: verification/lapt_chk.sv */
`timescale 1ns/10ps
module lapt_chk (
	input wire logic                 I_CLOCK,
	input wire logic                 I_RST_N,
	input wire logic                 I_PSEL,
	input wire logic                 I_PENABLE,
	input wire logic                 I_PWRITE,
	input wire logic [7:0]           I_PADDR,
	input wire logic [31:0]          I_PWDATA,
	input wire logic                 O_PREADY,
	input wire logic                 O_PSLVERR,
	input wire logic                 I_TAKE,
	input wire logic                 I_CLIP_LOAD,
	input wire logic                 I_CLIP_HAS_CFG,
	input wire lapt_pkg::lapt_clip_s I_CLIP_CFG,
	input wire logic                 I_LTC_LOCK,
	input wire logic                 I_LTC_STB,
	input wire logic [13:0]          O_FRAME_IDX,
	input wire logic                 O_PLAYING,
	input wire logic [16:0]          O_CROP_W,
	input wire logic [1:0]           O_PLAY_MODE,
	input wire lapt_pkg::lapt_ovl_s  O_OVERLAY
);
	logic [10:0] ctl_q;
	logic [6:0]  ff_v;
	logic [6:0]  ffmax;
	default clocking @(posedge I_CLOCK); endclocking
	default disable iff (!I_RST_N);
	// Shadow of CTRL; a load wins over a same-cycle bus write
	always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			ctl_q <= 11'h000;
		end else if (I_CLIP_LOAD) begin
			ctl_q[0] <= I_CLIP_HAS_CFG ? I_CLIP_CFG.auto_start : ctl_q[0];
		end else if (I_PSEL && I_PENABLE && O_PREADY && I_PWRITE && I_PADDR == 8'h00) begin
			ctl_q <= I_PWDATA[10:0];
		end
	end
	assign ff_v = 7'(O_OVERLAY.digits[1]) * 7'h0A + 7'(O_OVERLAY.digits[0]);
	always_comb begin
		case (ctl_q[10:8])
			3'h1, 3'h3: ffmax = lapt_pkg::FF_MAX_50I;
			3'h4, 3'h5: ffmax = lapt_pkg::FF_MAX_SF;
			3'h6:       ffmax = lapt_pkg::FF_MAX_50P;
			3'h7:       ffmax = lapt_pkg::FF_MAX_59P;
			default:    ffmax = lapt_pkg::FF_MAX_59I;
		endcase
	end
	property p_rdy; I_PSEL && !I_PENABLE |=> O_PREADY ##1 !O_PREADY; endproperty
	a_rdy: assert property (p_rdy) else $error("ready not a single pulse after setup");
	property p_err; O_PREADY && I_PADDR > 8'h20 |-> O_PSLVERR; endproperty
	a_err: assert property (p_err) else $error("no error on unmapped address");
	property p_take; I_TAKE && ctl_q[0] |=> ##1 O_FRAME_IDX == 14'h0000 && O_PLAYING; endproperty
	a_take: assert property (p_take) else $error("take did not restart");
	property p_mode;
		ctl_q == $past(ctl_q) && ctl_q == $past(ctl_q, 2) && ctl_q[10:9] != 2'h2
			|-> O_PLAY_MODE == (ctl_q[10] ? 2'h0 : ctl_q[5:4]);
	endproperty
	a_mode: assert property (p_mode) else $error("play mode wrong for format");
	property p_crop;
		ctl_q == $past(ctl_q) && ctl_q == $past(ctl_q, 2)
			|-> O_CROP_W <= (ctl_q[10] ? lapt_pkg::MAX_W_PROG : lapt_pkg::MAX_W_INTL);
	endproperty
	a_crop: assert property (p_crop) else $error("crop width too large");
	property p_ff; $stable(ctl_q) && I_LTC_STB ##1 $stable(ctl_q) ##1 $stable(ctl_q) |-> ff_v <= ffmax;
	endproperty
	a_ff: assert property (p_ff) else $error("ff too high");
	property p_dash; !I_LTC_LOCK [*8] |-> O_OVERLAY.dashes; endproperty
	a_dash: assert property (p_dash) else $error("digits shown without timecode");
	property p_live; I_LTC_LOCK [*8] |-> !O_OVERLAY.dashes; endproperty
	a_live: assert property (p_live) else $error("dashes shown with timecode");
	property p_size; ctl_q == $past(ctl_q) && ctl_q == $past(ctl_q, 2) |-> O_OVERLAY.size == ctl_q[7:6];
	endproperty
	a_size: assert property (p_size) else $error("overlay size mismatch");
	property p_len; O_FRAME_IDX < 14'h2710; endproperty
	a_len: assert property (p_len) else $error("frame index past limit");
	c_take: cover property (I_TAKE && ctl_q[0]);
	c_err: cover property (O_PSLVERR);
	c_live: cover property (O_OVERLAY.dashes ##1 !O_OVERLAY.dashes);
endmodule
bind lapt_core lapt_chk u_chk (
	.I_CLOCK(I_CLOCK), .I_RST_N(I_RST_N), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE),
	.I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA), .O_PREADY(O_PREADY),
	.O_PSLVERR(O_PSLVERR), .I_TAKE(I_TAKE), .I_CLIP_LOAD(I_CLIP_LOAD),
	.I_CLIP_HAS_CFG(I_CLIP_HAS_CFG), .I_CLIP_CFG(I_CLIP_CFG), .I_LTC_LOCK(I_LTC_LOCK),
	.I_LTC_STB(I_LTC_STB), .O_FRAME_IDX(O_FRAME_IDX), .O_PLAYING(O_PLAYING),
	.O_CROP_W(O_CROP_W), .O_PLAY_MODE(O_PLAY_MODE), .O_OVERLAY(O_OVERLAY)
);

/* File: verification/lapt_vsrc.sv */
`timescale 1ns/10ps
module lapt_vsrc (
	input  wire logic               i_clk,
	input  wire logic               i_rst_n,
	input  wire logic               i_go,
	input  wire logic               i_lock,
	input  wire logic               i_send,
	input  wire lapt_pkg::lapt_tc_s i_tc,
	output logic                    o_sync,
	output logic                    o_lock,
	output logic                    o_stb,
	output lapt_pkg::lapt_tc_s      o_tc
);
	logic [4:0] cnt_q;
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cnt_q <= 5'h00;
		end else if (i_go) begin
			cnt_q <= 5'h01;
		end else if (cnt_q != 5'h00) begin
			cnt_q <= cnt_q + 5'h01;
		end
	end
	// Five clocks high, more than the input stage needs to see it
	assign o_sync = cnt_q >= 5'h01 && cnt_q <= 5'h05;
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_stb <= 1'b0;
			o_lock <= 1'b0;
			o_tc <= '0;
		end else begin
			o_lock <= i_lock;
			// Timecode lands after the frame edge, only on frames the bench picks
			if (i_lock && i_send && cnt_q == 5'h0B) begin
				o_stb <= 1'b1;
				o_tc <= i_tc;
			end else begin
				o_stb <= 1'b0;
				o_tc <= ~o_tc;
			end
		end
	end
endmodule

/* File: verification/tb.sv */
`timescale 1ns/10ps
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin error_cnt++; \
	$display("wrong value %s exp %0h got %0h", n, e, a); end end
module tb;
	logic                 clk, rst_n, psel, pen, pwr, take, load, hcfg, go, lock, snd;
	logic                 pready, perr, sync, lk, stb, playing, rerr;
	logic [7:0]           paddr;
	logic [31:0]          pwd, prdata, rdat;
	logic [13:0]          clen, fidx;
	logic [16:0]          cw, cropw;
	logic [15:0]          ch, xpos, ypos, croph;
	logic [1:0]           pmode;
	lapt_pkg::lapt_clip_s cfg;
	lapt_pkg::lapt_tc_s   tc, ltc;
	lapt_pkg::lapt_ovl_s  ovl;
	int                   error_cnt = 0;
	int                   checks = 0;
	lapt_core dut (.I_CLOCK(clk), .I_RST_N(rst_n), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr),
		.I_PADDR(paddr), .I_PWDATA(pwd), .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(perr),
		.I_FRAME_SYNC(sync), .I_TAKE(take), .I_CLIP_LOAD(load), .I_CLIP_HAS_CFG(hcfg),
		.I_CLIP_CFG(cfg), .I_CLIP_LEN(clen), .I_CLIP_W(cw), .I_CLIP_H(ch), .I_LTC_LOCK(lk),
		.I_LTC_STB(stb), .I_LTC_TC(ltc), .O_FRAME_IDX(fidx), .O_PLAYING(playing), .O_XPOS(xpos),
		.O_YPOS(ypos), .O_CROP_W(cropw), .O_CROP_H(croph), .O_PLAY_MODE(pmode), .O_OVERLAY(ovl));
	lapt_vsrc u_src (.i_clk(clk), .i_rst_n(rst_n), .i_go(go), .i_lock(lock), .i_send(snd),
		.i_tc(tc), .o_sync(sync), .o_lock(lk), .o_stb(stb), .o_tc(ltc));
	task automatic end_sim;
		$display("checks %0d mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic w(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwr <= wr;
		paddr <= a;
		pwd <= d;
		@(posedge clk);
		pen <= 1'b1;
		// No assumed latency: a slave that never answers is caught by the watchdog
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rdat = prdata;
		rerr = perr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	task automatic tk;
		@(posedge clk);
		take <= 1'b1;
		@(posedge clk);
		take <= 1'b0;
		w(3);
	endtask
	task automatic ld(input logic h, input lapt_pkg::lapt_clip_s c);
		@(posedge clk);
		load <= 1'b1;
		hcfg <= h;
		cfg <= c;
		clen <= 14'h0005;
		cw <= 17'h00123;
		@(posedge clk);
		load <= 1'b0;
		w(3);
	endtask
	// Frame sync pulse; s says whether timecode rides on this frame
	task automatic fr(input logic s);
		@(posedge clk);
		go <= 1'b1;
		snd <= s;
		@(posedge clk);
		go <= 1'b0;
		w(20);
	endtask
	task automatic t_regs;
		apb(0, lapt_pkg::REG_CTRL, 0);
		`CHK("ctrl reset", 32'h0, rdat)
		apb(0, lapt_pkg::REG_LENGTH, 0);
		`CHK("length reset", 32'h1, rdat)
		apb(1, lapt_pkg::REG_LENGTH, 32'h3A98);
		apb(0, lapt_pkg::REG_LENGTH, 0);
		`CHK("length cap", 32'h2710, rdat)
		apb(0, 8'h24, 0);
		`CHK("unmapped err", 1'b1, rerr)
		apb(1, lapt_pkg::REG_STATUS, 32'hFFFFFFFF);
		`CHK("status write err", 1'b0, rerr)
		$display("test regs done");
	endtask
	task automatic t_seq;
		apb(1, lapt_pkg::REG_LENGTH, 32'h3);
		apb(1, lapt_pkg::REG_CTRL, 32'h1);
		tk;
		`CHK("take frame", 14'h0, fidx)
		fr(0);
		fr(0);
		fr(0);
		fr(0);
		`CHK("once last", 14'h2, fidx)
		`CHK("once stopped", 1'b0, playing)
		apb(1, lapt_pkg::REG_CTRL, 32'h0);
		tk;
		`CHK("manual take frame", 14'h2, fidx)
		`CHK("manual take state", 1'b0, playing)
		apb(1, lapt_pkg::REG_CTRL, 32'h3);
		tk;
		fr(0);
		tk;
		`CHK("retake", 14'h0, fidx)
		fr(0);
		fr(0);
		fr(0);
		`CHK("wrap", 14'h0, fidx)
		apb(1, lapt_pkg::REG_DWELL, 32'h2);
		apb(1, lapt_pkg::REG_CTRL, 32'h7);
		tk;
		fr(0);
		fr(0);
		fr(0);
		apb(0, lapt_pkg::REG_STATUS, 0);
		`CHK("dwell status", 18'h30002, rdat[17:0])
		fr(0);
		`CHK("dwell held", 14'h2, fidx)
		fr(0);
		`CHK("dwell wrap", 14'h0, fidx)
		$display("test sequencer done");
	endtask
	task automatic t_clip;
		apb(1, lapt_pkg::REG_CTRL, 32'h3);
		ld(0, '0);
		apb(0, lapt_pkg::REG_CTRL, 0);
		`CHK("kept settings", 3'h3, rdat[2:0])
		`CHK("load start", 14'h0, fidx)
		apb(0, lapt_pkg::REG_IMG_W, 0);
		`CHK("load width", 32'h123, rdat)
		ld(1, '{auto_start: 1'b0, loop: 1'b1, dwell_en: 1'b0, dwell: 16'h0, xpos: 16'h0, ypos: 16'h0});
		apb(0, lapt_pkg::REG_CTRL, 0);
		`CHK("stored settings", 3'h2, rdat[2:0])
		$display("test clip done");
	endtask
	task automatic t_geom;
		apb(1, lapt_pkg::REG_CTRL, 32'h0);
		apb(1, lapt_pkg::REG_IMG_W, 32'h64);
		apb(1, lapt_pkg::REG_IMG_H, 32'h32);
		apb(1, lapt_pkg::REG_XPOS, 32'h3E8);
		apb(1, lapt_pkg::REG_YPOS, 32'h3E8);
		w(3);
		`CHK("x clamp", 16'h026C, xpos)
		`CHK("y clamp", 16'h01B4, ypos)
		apb(1, lapt_pkg::REG_IMG_W, 32'h2D0);
		apb(1, lapt_pkg::REG_IMG_H, 32'h1E6);
		w(3);
		`CHK("full x", 16'h0, xpos)
		`CHK("full y", 16'h0, ypos)
		`CHK("crop h", 16'h01E6, croph)
		apb(1, lapt_pkg::REG_IMG_W, 32'h9C40);
		w(3);
		`CHK("crop intl", 17'h08000, cropw)
		apb(1, lapt_pkg::REG_CTRL, 32'h600);
		w(3);
		`CHK("crop prog", 17'h09C40, cropw)
		$display("test geometry done");
	endtask
	task automatic t_tc;
		logic [2:0] fm [8] = '{3'h7, 3'h6, 3'h0, 3'h1, 3'h4, 3'h5, 3'h2, 3'h3};
		int         lf [8] = '{10, 24, 29, 27, 25, 25, 31, 30};
		int         ex [8] = '{20, 48, 29, 24, 23, 23, 29, 24};
		int         e;
		fr(0);
		`CHK("no input dashes", 1'b1, ovl.dashes)
		@(posedge clk);
		lock <= 1'b1;
		w(8);
		for (int i = 0; i < 8; i++) begin
			apb(1, lapt_pkg::REG_CTRL, {21'h0, fm[i], 2'(i % 3), 6'h20});
			tc <= '{drop: 1'(i), hh: 7'h01, mm: 7'h02, ss: 7'h03, ff: 7'(lf[i])};
			fr(1);
			e = ex[i];
			`CHK("ff", 8'(e/10*16+e%10), ovl.digits[1:0])
			`CHK("hhmmss", 24'h010203, ovl.digits[7:2])
			`CHK("drop", 1'(i), ovl.drop)
			`CHK("live", 1'b0, ovl.dashes)
			`CHK("size", 2'(i % 3), ovl.size)
			if (fm[i] != 3'h4 && fm[i] != 3'h5)
				`CHK("mode", (fm[i] > 3'h5 ? 2'h0 : 2'h2), pmode)
			if (fm[i] > 3'h5) begin
				fr(0);
				e++;
				`CHK("ff step", 8'(e/10*16+e%10), ovl.digits[1:0])
			end
		end
		apb(0, lapt_pkg::REG_TCODE, 0);
		`CHK("tcode reg", 32'h01020324, rdat)
		$display("test timecode done");
	endtask
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		#400us;
		error_cnt++;
		end_sim;
	end
	initial begin
		{rst_n, psel, pen, pwr, take, load, hcfg, go, lock, snd} = '0;
		paddr = 8'h00;
		pwd = 32'h0;
		cfg = '0;
		tc = '0;
		clen = 14'h0;
		cw = 17'h0;
		ch = 16'h0;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		w(6);
		t_regs;
		t_seq;
		t_clip;
		t_geom;
		t_tc;
		end_sim;
	end
endmodule
